/* design/vrct_pkg.sv */
// vrct_pkg: constants and carrier types for the raster and
// character-cell timing generator.
// assumes: a single core clock; the dot rate is derived from it.
package vrct_pkg;

  // -------------------------------------------------------------
  // clocking and rates
  // -------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ = 125000000;
  localparam int unsigned DOT_CLK_HZ = 15148800;
  localparam int unsigned FIELD_RATE_HZ = 60;
  localparam int unsigned ACC_W = 28;

  // -------------------------------------------------------------
  // raster geometry
  // -------------------------------------------------------------
  localparam int unsigned CELL_DOTS = 10;
  localparam int unsigned CELL_LINES = 10;
  localparam int unsigned VIS_COLS = 80;
  localparam int unsigned VIS_ROWS = 25;
  localparam int unsigned VIS_DOTS = 800;
  localparam int unsigned FIELD_LINES = 263;
  localparam int unsigned FIELD_VIS_LINES = 250;
  localparam int unsigned FRAME_LINES = 526;
  localparam int unsigned FRAME_VIS_LINES = 500;
  // line total in dots follows from dot rate, field rate and lines
  localparam int unsigned LINE_DOTS =
    DOT_CLK_HZ / (FIELD_RATE_HZ * FIELD_LINES);
  localparam int unsigned LINE_CHARS = LINE_DOTS / CELL_DOTS;

  // glyph window inside a cell: columns 1..7, lines 0..8
  localparam logic [3:0] GLYPH_COL_FIRST = 4'h1;
  localparam logic [3:0] GLYPH_COL_LAST = 4'h7;
  localparam logic [3:0] GLYPH_LINE_LAST = 4'h8;
  localparam logic [3:0] DESC_LINE_FIRST = 4'h7;
  localparam logic [3:0] CHAR_CLK_HIGH_DOTS = 4'h5;

  // drive pulse placement, in character columns and field lines
  localparam logic [6:0] HDRV_START_COL = 7'h54;
  localparam logic [6:0] HDRV_END_COL = 7'h5C;
  localparam logic [8:0] VDRV_START_LINE = 9'h0FD;
  localparam logic [8:0] VDRV_END_LINE = 9'h100;

  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [0:0] {
    VRCT_FIELD_A = 1'b0,
    VRCT_FIELD_B = 1'b1
  } vrct_field_t;

  typedef struct packed {
    logic [3:0] dot_in_cell;
    logic [6:0] char_col;
    logic [4:0] char_row;
    logic [3:0] line_in_row;
    logic [8:0] field_line;
    vrct_field_t field;
  } vrct_pos_t;

  typedef struct packed {
    logic dot_tick;
    logic char_clk;
    logic hblank;
    logic vblank;
    logic hdrive;
    logic vdrive;
    logic glyph_en;
    logic descender;
  } vrct_sig_t;

endpackage : vrct_pkg

/* design/vrct_timing.sv */
// vrct_timing: raster, field and character-cell timing generator.
// assumes: core_clk at 125 MHz, synchronous active-high reset, and an
// interlace strap pin from outside the clock domain.
`timescale 1ns/1ps

// Summary of operation
// [R1] dots advance left to right; line counter steps only at end of line
// [R2] a frame is 526 lines made of field A then field B
// [R3] each field has 263 lines, first 250 visible, rest blanked
// [R4] line length chosen so fields come at 60 per second
// [R5] each line is 800 visible picture elements, one per dot tick
// [R6] picture data only inside 500 lines by 800 elements per frame
// [R7] standard mode: both fields drive on the same lines and overlay
// [R8] interlace mode: field B drive starts half a line late to interleave
// [R9] visible area is 25 character rows of 80 columns
// [R10] cell is 10 dots by 10 lines, both counters modulo ten
// [R11] left column, two right columns and bottom line stay blank
// [R12] glyph window is 7 by 9, bottom two lines flagged as descender
// [R13] dot tick rate is a nominal 15.1488 MHz from the core clock
// [R14] character clock is the dot rate divided by ten
// [R15] blanking outside 800 elements and during vertical retrace
// [R16] column, row and line-in-row counts are exported
module vrct_timing #(
  parameter int unsigned LINE_CHARS_P = vrct_pkg::LINE_CHARS
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic interlace_pin,
  output vrct_pkg::vrct_pos_t pos,
  output vrct_pkg::vrct_sig_t sig
);
  import vrct_pkg::*;

  // -------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------
  if (LINE_CHARS_P <= VIS_COLS || LINE_CHARS_P > 127) begin : g_bad
    $error("line length must exceed the visible columns and fit 7 bits");
  end

  // the drive pulse must fit inside the line, or the monitor never locks
  if (LINE_CHARS_P < int'(HDRV_END_COL)) begin : g_short
    $error("line length must reach past the horizontal drive pulse");
  end

  localparam logic [6:0] LAST_COL = 7'(LINE_CHARS_P - 1); // R4
  localparam logic [6:0] VIS_COLS_C = 7'(VIS_COLS);
  localparam logic [8:0] LAST_LINE = 9'(FIELD_LINES - 1);
  localparam logic [8:0] VIS_LINES_C = 9'(FIELD_VIS_LINES);
  localparam logic [3:0] LAST_DOT = 4'(CELL_DOTS - 1);
  localparam logic [3:0] CELL_LINES_C = 4'(CELL_LINES);
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(DOT_CLK_HZ);
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CORE_CLK_HZ);

  // -------------------------------------------------------------
  // interlace strap synchroniser
  // -------------------------------------------------------------
  logic intl_s1_r;
  logic intl_s2_r;
  logic intl_r;
  logic intl_nxt;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      intl_s1_r <= 1'b0;
      intl_s2_r <= 1'b0;
    end else begin
      intl_s1_r <= interlace_pin;
      intl_s2_r <= intl_s1_r;
    end
  end

  // -------------------------------------------------------------
  // dot rate accumulator
  // -------------------------------------------------------------
  // fractional divider: average rate is exact, single ticks jitter by
  // one core cycle, which a monitor cannot see at this dot size
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    logic [ACC_W-1:0] sum;
    sum = acc_r + ACC_STEP;
    if (sum >= ACC_MOD) begin
      acc_nxt = sum - ACC_MOD; // R13
      tick_nxt = 1'b1;
    end else begin
      acc_nxt = sum;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      acc_r <= '0;
      tick_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      tick_r <= tick_nxt;
    end
  end

  // -------------------------------------------------------------
  // raster counters
  // -------------------------------------------------------------
  logic [3:0] dot_r, dot_nxt;
  logic [6:0] col_r, col_nxt;
  logic [8:0] line_r, line_nxt;
  logic [4:0] row_r, row_nxt;
  logic [3:0] lir_r, lir_nxt;
  vrct_field_t field_r, field_nxt;
  logic end_of_line;

  assign end_of_line = tick_r && dot_r == LAST_DOT && col_r == LAST_COL;

  always_comb begin
    logic [3:0] lir_sum;
    // both modes walk every cell line in each field; interlace only
    // moves the vertical drive, so the text stays 25 rows high
    lir_sum = lir_r + 4'h1;
    dot_nxt = dot_r;
    col_nxt = col_r;
    line_nxt = line_r;
    row_nxt = row_r;
    lir_nxt = lir_r;
    field_nxt = field_r;
    intl_nxt = intl_r;
    if (tick_r) begin
      dot_nxt = (dot_r == LAST_DOT) ? 4'h0 : dot_r + 4'h1; // R10
      if (dot_r == LAST_DOT) begin
        col_nxt = (col_r == LAST_COL) ? 7'h00 : col_r + 7'h01; // R1
      end
    end
    if (end_of_line) begin
      if (line_r == LAST_LINE) begin
        // mode is taken only at a field boundary so a strap change
        // never tears a field
        line_nxt = 9'h000; // R3
        field_nxt = (field_r == VRCT_FIELD_A) ? VRCT_FIELD_B
                                              : VRCT_FIELD_A; // R2
        intl_nxt = intl_s2_r;
        row_nxt = 5'h00;
        lir_nxt = 4'h0; // R10
      end else begin
        line_nxt = line_r + 9'h001; // R1
        if (line_r < VIS_LINES_C) begin
          if (lir_sum >= CELL_LINES_C) begin
            lir_nxt = lir_sum - CELL_LINES_C; // R10
            row_nxt = row_r + 5'h01; // R9
          end else begin
            lir_nxt = lir_sum;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dot_r <= 4'h0;
      col_r <= 7'h00;
      line_r <= 9'h000;
      row_r <= 5'h00;
      lir_r <= 4'h0;
      field_r <= VRCT_FIELD_A;
      intl_r <= 1'b0;
    end else begin
      dot_r <= dot_nxt;
      col_r <= col_nxt;
      line_r <= line_nxt;
      row_r <= row_nxt;
      lir_r <= lir_nxt;
      field_r <= field_nxt;
      intl_r <= intl_nxt;
    end
  end

  // -------------------------------------------------------------
  // derived signals and output registers
  // -------------------------------------------------------------
  vrct_pos_t pos_r, pos_nxt;
  vrct_sig_t sig_r, sig_nxt;
  logic h_vis;
  logic v_vis;
  logic half_ok;

  assign h_vis = col_r < VIS_COLS_C; // R5 R15
  assign v_vis = line_r < VIS_LINES_C; // R3 R15
  // in interlace mode field B drive starts half a line late
  assign half_ok = !(intl_r && field_r == VRCT_FIELD_B) || // R7 R8
                   col_r >= 7'(LINE_CHARS_P / 2);

  always_comb begin
    pos_nxt.dot_in_cell = dot_r; // R16
    pos_nxt.char_col = col_r;
    pos_nxt.char_row = row_r;
    pos_nxt.line_in_row = lir_r;
    pos_nxt.field_line = line_r;
    pos_nxt.field = field_r;
    sig_nxt.dot_tick = tick_r;
    sig_nxt.char_clk = dot_r < CHAR_CLK_HIGH_DOTS; // R14
    sig_nxt.hblank = !h_vis; // R15
    sig_nxt.vblank = !v_vis; // R15
    sig_nxt.hdrive = col_r >= HDRV_START_COL && col_r < HDRV_END_COL;
    sig_nxt.vdrive = (line_r > VDRV_START_LINE ||
                      (line_r == VDRV_START_LINE && half_ok)) &&
                     (line_r < VDRV_END_LINE ||
                      (line_r == VDRV_END_LINE && !half_ok));
    sig_nxt.glyph_en = h_vis && v_vis &&
                       dot_r >= GLYPH_COL_FIRST &&
                       dot_r <= GLYPH_COL_LAST &&
                       lir_r <= GLYPH_LINE_LAST; // R6 R11 R12
    sig_nxt.descender = sig_nxt.glyph_en &&
                        lir_r >= DESC_LINE_FIRST; // R12
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pos_r <= '0;
      sig_r <= '0;
    end else begin
      pos_r <= pos_nxt;
      sig_r <= sig_nxt;
    end
  end

  assign pos = pos_r;
  assign sig = sig_r;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  // independent line count, so the field length check does not lean on
  // the line counter that it is meant to judge
  logic [8:0] lines_seen_r;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lines_seen_r <= 9'h000;
    end else if (end_of_line) begin
      lines_seen_r <= (line_r == LAST_LINE) ? 9'h000
                                            : lines_seen_r + 9'h001;
    end
  end

  a_dot_wraps: assert property (@(posedge core_clk) disable iff (reset) // R10
    tick_r && dot_r == LAST_DOT |=> dot_r == 4'h0)
    else $error("dot counter did not wrap at ten");
  a_line_holds: assert property (@(posedge core_clk) disable iff (reset) // R1
    !end_of_line |=> line_r == $past(line_r))
    else $error("line moved outside end of line");
  a_field_len: assert property (@(posedge core_clk) disable iff (reset) // R3
    end_of_line && line_r == LAST_LINE |-> lines_seen_r == LAST_LINE)
    else $error("field length is not 263 lines");
  a_field_flip: assert property (@(posedge core_clk) disable iff (reset) // R2
    end_of_line && line_r == LAST_LINE |=> field_r != $past(field_r))
    else $error("field did not alternate");
  a_glyph_blank: assert property (@(posedge core_clk) // R11
    disable iff (reset)
    sig_r.glyph_en |-> pos_r.dot_in_cell inside {[1:7]} &&
                       pos_r.line_in_row != 4'h9)
    else $error("glyph enabled in a spacing dot");
  a_hblank_vis: assert property (@(posedge core_clk) disable iff (reset) // R15
    sig_r.hblank |-> pos_r.char_col >= VIS_COLS_C && !sig_r.glyph_en)
    else $error("hblank inside visible columns");
  a_vblank_vis: assert property (@(posedge core_clk) disable iff (reset) // R6
    sig_r.vblank |-> pos_r.field_line >= VIS_LINES_C && !sig_r.glyph_en)
    else $error("vblank inside visible lines");
  a_tick_rate: assert property (@(posedge core_clk) disable iff (reset) // R13
    tick_r |=> !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1
               !tick_r ##1 !tick_r [*1] ##[1:2] tick_r)
    else $error("dot tick spacing is not 8 or 9 cycles");
  a_row_bound: assert property (@(posedge core_clk) disable iff (reset) // R9
    line_r < VIS_LINES_C |-> row_r < 5'(VIS_ROWS))
    else $error("character row beyond 25 in visible area");
  a_field_start: assert property (@(posedge core_clk) // R10
    disable iff (reset)
    end_of_line && line_r == LAST_LINE |=> lir_r == 4'h0 && row_r == 5'h00)
    else $error("field did not restart at the top cell line");

  // drive pulses: the half-line shift is the only difference between
  // the two modes, so both sides of it are guarded
  a_intl_half: assert property (@(posedge core_clk) disable iff (reset) // R8
    intl_r && field_r == VRCT_FIELD_B && line_r == VDRV_START_LINE &&
    col_r < 7'(LINE_CHARS_P / 2) |=> !sig_r.vdrive)
    else $error("interlaced field B drive did not wait half a line");
  a_std_overlay: assert property (@(posedge core_clk) disable iff (reset) // R7
    !intl_r && line_r == VDRV_START_LINE |=> sig_r.vdrive)
    else $error("standard mode drive not on the same line in each field");
  a_hdrive_blank: assert property (@(posedge core_clk) // R15
    disable iff (reset)
    sig_r.hdrive |-> sig_r.hblank)
    else $error("horizontal drive inside visible columns");
  a_vdrive_blank: assert property (@(posedge core_clk) // R3
    disable iff (reset)
    sig_r.vdrive |-> sig_r.vblank)
    else $error("vertical drive inside visible lines");

  c_field_b: cover property (@(posedge core_clk) disable iff (reset)
    end_of_line && line_r == LAST_LINE && field_r == VRCT_FIELD_B);
  c_row_step: cover property (@(posedge core_clk) disable iff (reset)
    end_of_line && row_nxt != row_r);
  c_intl_on: cover property (@(posedge core_clk) disable iff (reset)
    intl_r && field_r == VRCT_FIELD_B);
  c_descender: cover property (@(posedge core_clk) disable iff (reset)
    sig_r.descender);
  c_intl_half: cover property (@(posedge core_clk) disable iff (reset)
    intl_r && field_r == VRCT_FIELD_B && line_r == VDRV_START_LINE &&
    half_ok);

endmodule : vrct_timing

/* bench/vrct_crt_monitor.sv */
// vrct_crt_monitor: behavioural stand-in for the crt monitor that
// takes the raster position and blanking from the timing generator.
// assumes: one core clock, position outputs stand between dot ticks.
`timescale 1ns/1ps

module vrct_crt_monitor (
  input wire logic core_clk,
  input wire logic reset,
  input vrct_pkg::vrct_pos_t pos,
  input vrct_pkg::vrct_sig_t sig,
  output logic [15:0] line_dots,
  output logic [15:0] vis_dots
);
  import vrct_pkg::*;

  // ---------------------------------------------------------------
  // dot counting per scan line
  // ---------------------------------------------------------------
  // counts dot steps, not ticks, so tick alignment does not matter
  vrct_pos_t prev_r;
  logic [15:0] all_r;
  logic [15:0] vis_r;

  always_ff @(posedge core_clk) begin
    prev_r <= pos;
    if (reset) begin
      // dot 0 of column 0 stands during reset and is visible
      all_r <= 16'h0001;
      vis_r <= 16'h0001;
      line_dots <= 16'h0000;
      vis_dots <= 16'h0000;
    end else if (pos.field_line != prev_r.field_line) begin
      line_dots <= all_r;
      vis_dots <= vis_r;
      // the first dot of a line arrives with the line step itself
      all_r <= 16'h0001;
      vis_r <= {15'h0000, !sig.hblank};
    end else if (pos.dot_in_cell != prev_r.dot_in_cell) begin
      all_r <= all_r + 16'h0001;
      if (!sig.hblank) begin
        vis_r <= vis_r + 16'h0001;
      end
    end
  end
endmodule : vrct_crt_monitor

/* bench/test_video_raster_char_cell_timing.sv */
// test_video_raster_char_cell_timing: self-checking bench for the
// raster timing generator with a short line total of 93 cells.
// assumes: vrct_timing and the crt monitor model compile before it.
`timescale 1ns/1ps

module test_video_raster_char_cell_timing;
  import vrct_pkg::*;

  localparam int unsigned CHARS = 93;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic interlace_pin = 1'b0;
  vrct_pos_t pos;
  vrct_sig_t sig;
  logic [15:0] line_dots;
  logic [15:0] vis_dots;
  int mismatches = 0;
  int num_checks = 0;

  always #4 core_clk = ~core_clk;

  vrct_timing #(.LINE_CHARS_P(CHARS)) u_dut (
    .core_clk(core_clk), .reset(reset), .interlace_pin(interlace_pin),
    .pos(pos), .sig(sig));

  vrct_crt_monitor u_mon (
    .core_clk(core_clk), .reset(reset), .pos(pos), .sig(sig),
    .line_dots(line_dots), .vis_dots(vis_dots));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic timed_out(string nm);
    mismatches++;
    $display("ERROR %s wait expected done seen timeout", nm);
    wrap_up();
  endtask : timed_out

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    repeat (4) tick();
    chk("pos in reset", 16'h0000, {15'h0000, pos !== '0});
    chk("sig in reset", 16'h0000, {15'h0000, sig !== '0});
    reset = 1'b0;
    $display("test reset done");
  endtask : t_reset

  // thousand ticks must take the core-to-dot ratio, within one cycle
  task automatic t_dot_rate();
    longint lo;
    int n, cyc, gap, bad;
    lo = longint'(CORE_CLK_HZ) * 1000 / DOT_CLK_HZ;
    n = 0; cyc = 0; gap = 0; bad = 0;
    while (!sig.dot_tick && cyc < 40) begin tick(); cyc++; end
    if (cyc >= 40) timed_out("first dot tick");
    cyc = 0;
    while (n < 1000 && cyc < 9000) begin
      tick(); cyc++; gap++;
      if (sig.dot_tick === 1'b1) begin
        if (gap < 8 || gap > 9) bad++;
        n++; gap = 0;
      end
    end
    if (n < 1000) timed_out("dot ticks");
    chk("dot tick gaps off 8 or 9", 16'h0000, 16'(bad));
    chk("cycles per 1000 dots", 16'(lo + (cyc > lo)), 16'(cyc));
    $display("test dot rate done");
  endtask : t_dot_rate

  // every cycle to the end of the current line: cell window, char clock, blanking
  task automatic t_cell();
    logic [8:0] ln;
    logic [3:0] d, dp;
    logic vis, gl, hd;
    int cyc;
    ln = pos.field_line; dp = pos.dot_in_cell; cyc = 0;
    while (pos.field_line == ln && cyc < 8000) begin
      tick(); cyc++;
      d = pos.dot_in_cell;
      vis = (pos.char_col < 7'h50) && (pos.field_line < 9'h0FA);
      gl = vis && d >= 4'h1 && d <= 4'h7 && pos.line_in_row <= 4'h8;
      hd = pos.char_col >= HDRV_START_COL && pos.char_col < HDRV_END_COL;
      chk("hblank", {15'h0, pos.char_col >= 7'h50},
          {15'h0, sig.hblank});
      chk("hdrive", {15'h0, hd}, {15'h0, sig.hdrive});
      chk("vdrive", 16'h0000, {15'h0, sig.vdrive});
      chk("field", 16'h0000, {15'h0, pos.field});
      chk("vblank", 16'h0000, {15'h0, sig.vblank});
      chk("char clk", {15'h0, d < 4'h5}, {15'h0, sig.char_clk});
      chk("glyph en", {15'h0, gl}, {15'h0, sig.glyph_en});
      chk("descender", {15'h0, gl && d >= 4'h0 && pos.line_in_row >= 4'h7},
          {15'h0, sig.descender});
      if (d != dp) begin
        chk("dot step", {12'h0, (dp == 4'h9) ? 4'h0 : dp + 4'h1},
            {12'h0, d});
        dp = d;
      end
    end
    if (cyc >= 8000) timed_out("line end");
    $display("test cell done");
  endtask : t_cell

  // nine lines: strap moves mid-field, rows still follow standard order
  task automatic t_rows();
    logic [8:0] ln;
    int cyc;
    interlace_pin = 1'b1;
    ln = pos.field_line; cyc = 0;
    while (pos.field_line < 9'h00B && cyc < 80000) begin
      tick(); cyc++;
      if (pos.field_line != ln) begin
        ln = pos.field_line;
        chk("line in row", {12'h0, 4'(ln % 10)},
            {12'h0, pos.line_in_row});
        chk("char row", {11'h0, 5'(ln / 10)}, {11'h0, pos.char_row});
        chk("column at line start", 16'h0000, {9'h0, pos.char_col});
        chk("dots per line", 16'(CHARS * 10), line_dots);
        chk("visible dots", 16'h0320, vis_dots);
      end
    end
    if (cyc >= 80000) timed_out("row end");
    interlace_pin = 1'b0;
    $display("test rows done");
  endtask : t_rows

  initial begin
    t_reset();
    t_dot_rate();
    t_cell();
    t_rows();
    wrap_up();
  end
endmodule : test_video_raster_char_cell_timing
